// ===== shared/net_join_cfg.svh
`ifndef NET_JOIN_CFG_SVH
`define NET_JOIN_CFG_SVH
// command selectors
`define SEL_ROLE      3'h0
`define SEL_MASK      3'h1
`define SEL_DWELL     3'h2
`define SEL_ENDDEV    3'h3
`define SEL_COORD     3'h4
`define SEL_STATUS    3'h5
// reset values
`define ROLE_RST      1'h0
`define MASK_RST      16'hFFFF
`define DWELL_RST     4'h4
`define ENDDEV_RST    4'h0
`define COORD_RST     3'h0
// field positions
`define OPT_ANY_NET   0
`define OPT_ANY_LANE  1
`define OPT_AUTO      2
`define OPT_FETCH     3
`define OPT_ALLOW     2
// lanes and masks
`define LANE_BASE     5'h0B
`define HP_MASK       16'h1FFE
`define FULL_MASK     16'hFFFF
`define BCAST_ADDR    16'hFFFF
// timing
`define CORE_CLK_KHZ  10000
`define DWELL_BASE_US 15360
`define CHAN_GAP_US   38000
`define SCAN_FIXED_US 20000
`define DWELL_BASE_CYC ((`DWELL_BASE_US * `CORE_CLK_KHZ + 999) / 1000)
`define CHAN_GAP_CYC   ((`CHAN_GAP_US * `CORE_CLK_KHZ + 999) / 1000)
`define SCAN_FIXED_CYC ((`SCAN_FIXED_US * `CORE_CLK_KHZ + 999) / 1000)
`endif

// ===== shared/net_join_pkg.sv
package net_join_pkg;
  typedef enum logic [4:0] {
    ST_IDLE   = 5'h01,
    ST_SURVEY = 5'h02,
    ST_ENERGY = 5'h04,
    ST_ASSOC  = 5'h08,
    ST_UP     = 5'h10
  } join_state_t;
  typedef enum logic [4:0] {
    PH_IDLE  = 5'h01,
    PH_FIXED = 5'h02,
    PH_PICK  = 5'h04,
    PH_DWELL = 5'h08,
    PH_GAP   = 5'h10
  } scan_phase_t;
endpackage

// ===== rtl/join_filter.sv
`timescale 1ns/10ps
`include "net_join_cfg.svh"
module join_filter (
  input  wire logic [3:0]  enddev_opts,  // end-device join options
  input  wire logic [15:0] own_tag,      // configured network_tag
  input  wire logic [4:0]  own_lane,     // configured radio_lane
  input  wire logic [15:0] seen_tag,     // beacon network tag
  input  wire logic [4:0]  seen_lane,    // beacon lane
  input  wire logic        seen_permit,  // beacon allows joining
  output logic             accept,       // coordinator may be joined
  output logic             tag_clash     // beacon uses our tag
);
  logic tag_ok;
  logic lane_ok;
  assign tag_ok    = enddev_opts[`OPT_ANY_NET] | (seen_tag == own_tag);
  assign lane_ok   = enddev_opts[`OPT_ANY_LANE] | (seen_lane == own_lane);
  assign accept    = seen_permit & tag_ok & lane_ok;
  assign tag_clash = (seen_tag == own_tag);
endmodule

// ===== rtl/scan_sequencer.sv
`timescale 1ns/10ps
`include "net_join_cfg.svh"
module scan_sequencer #(
  parameter int unsigned DWELL_BASE_CYC = `DWELL_BASE_CYC,
  parameter int unsigned CHAN_GAP_CYC   = `CHAN_GAP_CYC,
  parameter int unsigned SCAN_FIXED_CYC = `SCAN_FIXED_CYC
) (
  input  wire logic        core_clk,     // clock
  input  wire logic        rst_n,        // async reset
  input  wire logic        start,        // begin a survey
  input  wire logic        energy_kind,  // 1 energy, 0 beacon
  input  wire logic [15:0] mask,         // channel_mask
  input  wire logic [3:0]  exponent,     // dwell_exponent
  output logic             busy,         // survey running
  output logic             listen,       // dwelling on a lane
  output logic             energy_on,    // energy dwell
  output logic             bcn_req,      // beacon request pulse
  output logic [4:0]       lane,         // current lane
  output logic             done          // survey finished pulse
);
  net_join_pkg::scan_phase_t phase, next_phase;
  logic [31:0] cyc, next_cyc;
  logic [15:0] units, next_units;
  logic [3:0]  idx, next_idx;
  logic [15:0] mask_r, next_mask_r;
  logic        kind, next_kind;
  logic        next_bcn_req, next_done;
  logic [4:0]  next_lane;
  logic [15:0] unit_lim;

  // unit_lim = 2^exponent dwell units of one base period each
  assign unit_lim = 16'h0001 << exponent;
  assign busy      = (phase != net_join_pkg::PH_IDLE);
  assign listen    = (phase == net_join_pkg::PH_DWELL);
  assign energy_on = listen & kind;

  always_comb begin
    next_phase   = phase;
    next_cyc     = cyc;
    next_units   = units;
    next_idx     = idx;
    next_mask_r  = mask_r;
    next_kind    = kind;
    next_lane    = lane;
    next_bcn_req = 1'b0;
    next_done    = 1'b0;
    unique case (phase)
      net_join_pkg::PH_IDLE: begin
        if (start) begin
          next_phase  = net_join_pkg::PH_FIXED;
          next_cyc    = 32'h0;
          next_idx    = 4'h0;
          next_mask_r = mask;
          next_kind   = energy_kind;
        end
      end
      net_join_pkg::PH_FIXED: begin
        if (cyc == SCAN_FIXED_CYC - 32'h1) begin
          next_phase = net_join_pkg::PH_PICK;
          next_cyc   = 32'h0;
        end else begin
          next_cyc = cyc + 32'h1;
        end
      end
      net_join_pkg::PH_PICK: begin
        if (mask_r[idx]) begin
          next_phase   = net_join_pkg::PH_DWELL;
          next_cyc     = 32'h0;
          next_units   = 16'h0;
          next_lane    = `LANE_BASE + {1'b0, idx};
          next_bcn_req = ~kind;
        end else if (idx == 4'hF) begin
          next_phase = net_join_pkg::PH_IDLE;
          next_done  = 1'b1;
        end else begin
          next_idx = idx + 4'h1;
        end
      end
      net_join_pkg::PH_DWELL: begin
        if (cyc == DWELL_BASE_CYC - 32'h1) begin
          next_cyc = 32'h0;
          if (units == unit_lim - 16'h1) begin
            next_phase = net_join_pkg::PH_GAP;
          end else begin
            next_units = units + 16'h1;
          end
        end else begin
          next_cyc = cyc + 32'h1;
        end
      end
      net_join_pkg::PH_GAP: begin
        if (cyc == CHAN_GAP_CYC - 32'h1) begin
          next_cyc = 32'h0;
          if (idx == 4'hF) begin
            next_phase = net_join_pkg::PH_IDLE;
            next_done  = 1'b1;
          end else begin
            next_idx   = idx + 4'h1;
            next_phase = net_join_pkg::PH_PICK;
          end
        end else begin
          next_cyc = cyc + 32'h1;
        end
      end
      default: next_phase = net_join_pkg::PH_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase   <= net_join_pkg::PH_IDLE;
      cyc     <= 32'h0;
      units   <= 16'h0;
      idx     <= 4'h0;
      mask_r  <= 16'h0;
      kind    <= 1'b0;
      lane    <= `LANE_BASE;
      bcn_req <= 1'b0;
      done    <= 1'b0;
    end else begin
      phase   <= next_phase;
      cyc     <= next_cyc;
      units   <= next_units;
      idx     <= next_idx;
      mask_r  <= next_mask_r;
      kind    <= next_kind;
      lane    <= next_lane;
      bcn_req <= next_bcn_req;
      done    <= next_done;
    end
  end
endmodule

// ===== rtl/network_join_config.sv
`timescale 1ns/10ps
`include "net_join_cfg.svh"
module network_join_config #(
  parameter bit          HIGH_POWER     = 1'b0,
  parameter int unsigned DWELL_BASE_CYC = `DWELL_BASE_CYC,
  parameter int unsigned CHAN_GAP_CYC   = `CHAN_GAP_CYC,
  parameter int unsigned SCAN_FIXED_CYC = `SCAN_FIXED_CYC
) (
  input  wire logic        core_clk,        // clock
  input  wire logic        rst_n,           // async reset
  input  wire logic        cmd_valid,       // command strobe
  input  wire logic        cmd_write,       // 1 write, 0 read
  input  wire logic [2:0]  cmd_sel,         // setting selector
  input  wire logic [15:0] cmd_wdata,       // write value
  output logic             rsp_valid,       // answer pulse
  output logic             rsp_error,       // value refused
  output logic [15:0]      rsp_data,        // read value
  input  wire logic [15:0] own_network_tag, // configured tag
  input  wire logic [4:0]  own_radio_lane,  // configured lane
  input  wire logic        beacon_net,      // beacon-enabled network
  output logic             bcn_req,         // beacon request pulse
  output logic [15:0]      bcn_dest,        // request address
  output logic [4:0]       scan_lane,       // lane being surveyed
  output logic             energy_on,       // energy measuring
  output logic             survey_busy,     // survey in progress
  input  wire logic        beacon_seen,     // beacon received pulse
  input  wire logic [15:0] beacon_tag,      // its network tag
  input  wire logic [4:0]  beacon_lane,     // its lane
  input  wire logic        beacon_permit,   // it accepts joins
  input  wire logic        energy_valid,    // energy sample pulse
  input  wire logic [7:0]  energy_level,    // energy sample
  output logic             assoc_req,       // join attempt pulse
  output logic [15:0]      assoc_tag,       // target tag
  output logic [4:0]       assoc_lane,      // target lane
  input  wire logic        assoc_ok,        // join succeeded
  input  wire logic        assoc_fail,      // join failed
  input  wire logic        join_req,        // remote join request
  output logic             join_accept,     // request granted
  output logic             join_refuse,     // request refused
  input  wire logic        wake_pin,        // wake pin, async
  output logic             poll_req,        // poll coordinator pulse
  output logic             node_up,         // joined or started
  output logic             role_coord,      // role select
  output logic [15:0]      op_network_tag,  // operating tag
  output logic [4:0]       op_radio_lane    // operating lane
);
  // ---- settings and command port
  logic        role, next_role;
  logic [15:0] chan_mask, next_chan_mask;
  logic [3:0]  dwell_exp, next_dwell_exp;
  logic [3:0]  ed_opts, next_ed_opts;
  logic [2:0]  co_opts, next_co_opts;
  logic        kick, next_kick;
  logic        next_rsp_valid, next_rsp_error;
  logic [15:0] next_rsp_data;
  logic        kick_take;
  logic [15:0] avail_mask;

  net_join_pkg::join_state_t state, next_state;

  assign avail_mask = HIGH_POWER ? `HP_MASK : `FULL_MASK;
  assign role_coord = role;

  always_comb begin
    next_role      = role;
    next_chan_mask = chan_mask;
    next_dwell_exp = dwell_exp;
    next_ed_opts   = ed_opts;
    next_co_opts   = co_opts;
    next_rsp_valid = cmd_valid;
    next_rsp_error = 1'b0;
    next_rsp_data  = 16'h0;
    // a restart request landing with its consumption survives
    next_kick      = kick & ~kick_take;
    if (cmd_valid && cmd_write) begin
      unique case (cmd_sel)
        `SEL_ROLE: begin
          if (cmd_wdata > 16'h1) next_rsp_error = 1'b1;
          else next_role = cmd_wdata[0];
        end
        `SEL_MASK:  next_chan_mask = cmd_wdata & avail_mask;
        `SEL_DWELL: begin
          if (cmd_wdata > 16'h000F) next_rsp_error = 1'b1;
          else next_dwell_exp = cmd_wdata[3:0];
        end
        `SEL_ENDDEV: next_ed_opts = cmd_wdata[3:0];
        `SEL_COORD:  next_co_opts = cmd_wdata[2:0];
        `SEL_STATUS: next_kick    = 1'b1;
        default:     next_rsp_error = 1'b1;
      endcase
    end else if (cmd_valid) begin
      unique case (cmd_sel)
        `SEL_ROLE:   next_rsp_data = {15'h0, role};
        `SEL_MASK:   next_rsp_data = chan_mask;
        `SEL_DWELL:  next_rsp_data = {12'h0, dwell_exp};
        `SEL_ENDDEV: next_rsp_data = {12'h0, ed_opts};
        `SEL_COORD:  next_rsp_data = {13'h0, co_opts};
        `SEL_STATUS: next_rsp_data = {10'h0, survey_busy, state};
        default:     next_rsp_error = 1'b1;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      role      <= `ROLE_RST;
      chan_mask <= `MASK_RST & (HIGH_POWER ? `HP_MASK : `FULL_MASK);
      dwell_exp <= `DWELL_RST;
      ed_opts   <= `ENDDEV_RST;
      co_opts   <= `COORD_RST;
      kick      <= 1'b1;
      rsp_valid <= 1'b0;
      rsp_error <= 1'b0;
      rsp_data  <= 16'h0;
    end else begin
      role      <= next_role;
      chan_mask <= next_chan_mask;
      dwell_exp <= next_dwell_exp;
      ed_opts   <= next_ed_opts;
      co_opts   <= next_co_opts;
      kick      <= next_kick;
      rsp_valid <= next_rsp_valid;
      rsp_error <= next_rsp_error;
      rsp_data  <= next_rsp_data;
    end
  end

  // ---- survey engine and beacon check
  logic       scan_start, scan_energy, scan_listen, scan_done;
  logic       bcn_ok, bcn_clash;

  assign bcn_dest = `BCAST_ADDR;

  scan_sequencer #(
    .DWELL_BASE_CYC(DWELL_BASE_CYC),
    .CHAN_GAP_CYC  (CHAN_GAP_CYC),
    .SCAN_FIXED_CYC(SCAN_FIXED_CYC)
  ) u_scan (
    .core_clk   (core_clk),
    .rst_n      (rst_n),
    .start      (scan_start),
    .energy_kind(scan_energy),
    .mask       (chan_mask),
    .exponent   (dwell_exp),
    .busy       (survey_busy),
    .listen     (scan_listen),
    .energy_on  (energy_on),
    .bcn_req    (bcn_req),
    .lane       (scan_lane),
    .done       (scan_done)
  );

  join_filter u_filter (
    .enddev_opts(ed_opts),
    .own_tag    (own_network_tag),
    .own_lane   (own_radio_lane),
    .seen_tag   (beacon_tag),
    .seen_lane  (beacon_lane),
    .seen_permit(beacon_permit),
    .accept     (bcn_ok),
    .tag_clash  (bcn_clash)
  );

  // ---- joining and start-up sequence
  logic        found, next_found;
  logic        clash, next_clash;
  logic [15:0] cand_tag, next_cand_tag;
  logic [4:0]  cand_lane, next_cand_lane;
  logic [7:0]  best_energy, next_best_energy;
  logic [4:0]  best_lane, next_best_lane;
  logic [15:0] next_op_tag;
  logic [4:0]  next_op_lane;
  logic        next_assoc_req;
  logic        want_join;

  // auto joining only matters off-beacon; a beacon network always joins
  assign want_join = ed_opts[`OPT_AUTO] | beacon_net;
  assign node_up   = (state == net_join_pkg::ST_UP);
  assign assoc_tag  = cand_tag;
  assign assoc_lane = cand_lane;

  always_comb begin
    next_state       = state;
    next_found       = found;
    next_clash       = clash;
    next_cand_tag    = cand_tag;
    next_cand_lane   = cand_lane;
    next_best_energy = best_energy;
    next_best_lane   = best_lane;
    next_op_tag      = op_network_tag;
    next_op_lane     = op_radio_lane;
    next_assoc_req   = 1'b0;
    scan_start       = 1'b0;
    scan_energy      = 1'b0;
    kick_take        = 1'b0;
    unique case (state)
      net_join_pkg::ST_IDLE: begin
        if (kick) begin
          kick_take    = 1'b1;
          next_op_tag  = own_network_tag;
          next_op_lane = own_radio_lane;
          next_found   = 1'b0;
          next_clash   = 1'b0;
          if (role) begin
            if (co_opts[`OPT_ANY_NET]) begin
              next_state = net_join_pkg::ST_SURVEY;
              scan_start = 1'b1;
            end else if (co_opts[`OPT_ANY_LANE]) begin
              next_state       = net_join_pkg::ST_ENERGY;
              scan_start       = 1'b1;
              scan_energy      = 1'b1;
              next_best_energy = 8'hFF;
              next_best_lane   = own_radio_lane;
            end else begin
              next_state = net_join_pkg::ST_UP;
            end
          end else if (want_join) begin
            next_state = net_join_pkg::ST_SURVEY;
            scan_start = 1'b1;
          end
        end
      end
      net_join_pkg::ST_SURVEY: begin
        if (beacon_seen && scan_listen) begin
          if (role && bcn_clash) next_clash = 1'b1;
          if (!role && bcn_ok && !found) begin
            next_found     = 1'b1;
            next_cand_tag  = beacon_tag;
            next_cand_lane = beacon_lane;
          end
        end
        if (scan_done) begin
          if (role) begin
            // a clash moves to the next tag; the survey is not repeated
            if (clash) next_op_tag = own_network_tag + 16'h1;
            if (co_opts[`OPT_ANY_LANE]) begin
              next_state       = net_join_pkg::ST_ENERGY;
              scan_start       = 1'b1;
              scan_energy      = 1'b1;
              next_best_energy = 8'hFF;
              next_best_lane   = own_radio_lane;
            end else begin
              next_state = net_join_pkg::ST_UP;
            end
          end else if (found) begin
            next_state     = net_join_pkg::ST_ASSOC;
            next_assoc_req = 1'b1;
          end else if (want_join) begin
            scan_start = 1'b1;
          end else begin
            next_state = net_join_pkg::ST_IDLE;
          end
        end
      end
      net_join_pkg::ST_ENERGY: begin
        if (energy_valid && energy_on && energy_level < best_energy) begin
          next_best_energy = energy_level;
          next_best_lane   = scan_lane;
        end
        if (scan_done) begin
          next_op_lane = best_lane;
          next_state   = net_join_pkg::ST_UP;
        end
      end
      net_join_pkg::ST_ASSOC: begin
        if (assoc_ok) begin
          next_op_tag  = cand_tag;
          next_op_lane = cand_lane;
          next_state   = net_join_pkg::ST_UP;
        end else if (assoc_fail) begin
          next_found = 1'b0;
          next_state = net_join_pkg::ST_SURVEY;
          scan_start = 1'b1;
        end
      end
      net_join_pkg::ST_UP: begin
        if (kick) next_state = net_join_pkg::ST_IDLE;
      end
      default: next_state = net_join_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state          <= net_join_pkg::ST_IDLE;
      found          <= 1'b0;
      clash          <= 1'b0;
      cand_tag       <= 16'h0;
      cand_lane      <= `LANE_BASE;
      best_energy    <= 8'hFF;
      best_lane      <= `LANE_BASE;
      op_network_tag <= 16'h0;
      op_radio_lane  <= `LANE_BASE;
      assoc_req      <= 1'b0;
    end else begin
      state          <= next_state;
      found          <= next_found;
      clash          <= next_clash;
      cand_tag       <= next_cand_tag;
      cand_lane      <= next_cand_lane;
      best_energy    <= next_best_energy;
      best_lane      <= next_best_lane;
      op_network_tag <= next_op_tag;
      op_radio_lane  <= next_op_lane;
      assoc_req      <= next_assoc_req;
    end
  end

  // ---- pin wake and remote join requests
  logic wake_meta, wake_sync, wake_prev;
  logic next_poll, next_accept, next_refuse;

  always_comb begin
    next_poll   = 1'b0;
    next_accept = 1'b0;
    next_refuse = 1'b0;
    if (wake_sync && !wake_prev && !role && node_up && ed_opts[`OPT_FETCH]) begin
      next_poll = 1'b1;
    end
    if (join_req && role && node_up) begin
      next_accept = co_opts[`OPT_ALLOW];
      next_refuse = ~co_opts[`OPT_ALLOW];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wake_meta   <= 1'b0;
      wake_sync   <= 1'b0;
      wake_prev   <= 1'b0;
      poll_req    <= 1'b0;
      join_accept <= 1'b0;
      join_refuse <= 1'b0;
    end else begin
      wake_meta   <= wake_pin;
      wake_sync   <= wake_meta;
      wake_prev   <= wake_sync;
      poll_req    <= next_poll;
      join_accept <= next_accept;
      join_refuse <= next_refuse;
    end
  end
endmodule

// ===== verif/network_join_config_checker.sv
`timescale 1ns/10ps
module network_join_config_checker (
  input wire logic        core_clk, rst_n, cmd_valid, cmd_write, rsp_valid, rsp_error, // command side
  input wire logic        bcn_req, energy_on, survey_busy, node_up, role_coord,           // survey state
  input wire logic        join_req, join_accept, join_refuse,                             // remote joins
  input wire logic [2:0]  cmd_sel,                                                        // selector
  input wire logic [15:0] cmd_wdata, rsp_data, bcn_dest,                                  // data
  input wire logic [4:0]  scan_lane                                                       // lane
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  answer_due_a: assert property (cmd_valid |=> rsp_valid) else $error("command not answered");
  no_stray_a: assert property (!cmd_valid |=> !rsp_valid) else $error("answer without command");
  bad_sel_a: assert property (cmd_valid && cmd_sel > 3'h5 |=> rsp_error && rsp_data == 16'h0000)
    else $error("unmapped selector not refused");
  role_range_a: assert property (cmd_valid && cmd_write && cmd_sel == 3'h0 |=>
    rsp_error == ($past(cmd_wdata) > 16'h0001)) else $error("role range wrong");
  dwell_range_a: assert property (cmd_valid && cmd_write && cmd_sel == 3'h2 |=>
    rsp_error == ($past(cmd_wdata) > 16'h000F)) else $error("dwell range wrong");
  beacon_bcast_a: assert property (bcn_req |-> bcn_dest == 16'hFFFF && survey_busy && !energy_on
    && scan_lane >= 5'h0B && scan_lane <= 5'h1A) else $error("beacon request malformed");
  energy_busy_a: assert property (energy_on |-> survey_busy && !bcn_req)
    else $error("energy dwell outside survey");
  join_answer_a: assert property (join_req && node_up && role_coord |=> join_accept != join_refuse)
    else $error("join request not answered");
  join_quiet_a: assert property (!join_req |=> !join_accept && !join_refuse)
    else $error("join answer without request");
endmodule

// ===== verif/radio_peer.sv
`timescale 1ns/10ps
module radio_peer (
  input wire logic        core_clk, rst_n, bcn_req, energy_on, assoc_req, reject, // from node
  input wire logic [4:0]  scan_lane, quiet_lane,                                  // lanes
  input wire logic [15:0] peer_tag,                                               // our tag
  output logic            beacon_seen, beacon_permit, energy_valid, assoc_ok, assoc_fail, // answers
  output logic [15:0]     beacon_tag,                                             // beacon tag
  output logic [4:0]      beacon_lane,                                            // beacon lane
  output logic [7:0]      energy_level                                            // energy sample
);
  // one coordinator heard on every lane; released lines toggle so stale data is never trusted
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      {beacon_seen, beacon_permit, energy_valid, assoc_ok, assoc_fail} <= '0;
      beacon_tag <= 16'h0000;
      beacon_lane <= 5'h00;
      energy_level <= 8'h00;
    end else begin
      beacon_seen <= bcn_req;
      beacon_tag <= bcn_req ? peer_tag : ~beacon_tag;
      beacon_lane <= bcn_req ? scan_lane : ~beacon_lane;
      beacon_permit <= bcn_req ? 1'b1 : ~beacon_permit;
      energy_valid <= energy_on;
      energy_level <= (scan_lane == quiet_lane) ? 8'h10 : 8'h90;
      assoc_ok <= assoc_req && !reject;
      assoc_fail <= assoc_req && reject;
    end
  end
endmodule

// ===== verif/network_join_config_test.sv
`timescale 1ns/10ps
module network_join_config_test;
  logic core_clk, rst_n, cmd_valid, cmd_write, rsp_valid, rsp_error, beacon_net, bcn_req, energy_on, survey_busy;
  logic beacon_seen, beacon_permit, energy_valid, assoc_req, assoc_ok, assoc_fail, join_req, join_accept;
  logic join_refuse, wake_pin, poll_req, node_up, role_coord, reject;
  logic [2:0]  cmd_sel;
  logic [4:0]  own_radio_lane, scan_lane, beacon_lane, assoc_lane, op_radio_lane, quiet_lane;
  logic [7:0]  energy_level;
  logic [15:0] cmd_wdata, rsp_data, own_network_tag, bcn_dest, beacon_tag, assoc_tag, op_network_tag, peer_tag;
  int          n_errors, comparisons, cyc, polls, assocs;
  int          at[$];
  logic [4:0]  lanes[$];
  network_join_config #(.DWELL_BASE_CYC(4), .CHAN_GAP_CYC(3), .SCAN_FIXED_CYC(2)) i_network_join_config (.*);
  radio_peer i_radio_peer (.*);
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc++;
    if (bcn_req === 1'b1) begin
      lanes.push_back(scan_lane);
      at.push_back(cyc);
    end
    if (poll_req === 1'b1) polls++;
    if (assoc_req === 1'b1) assocs++;
    if (cyc == 20000) begin
      n_errors++;
      print_verdict;
    end
  end
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task cmd(input logic w, input logic [2:0] s, input logic [15:0] d, input logic e, input logic [15:0] x);
    @(posedge core_clk);
    cmd_valid <= 1'b1;
    cmd_write <= w;
    cmd_sel <= s;
    cmd_wdata <= d;
    @(posedge core_clk);
    cmd_valid <= 1'b0;
    #1;
    chk({14'h0000, rsp_valid, rsp_error}, {14'h0000, 1'b1, e});
    chk(rsp_data, x);
  endtask
  task restart;
    lanes.delete();
    at.delete();
    cmd(1'b1, 3'h5, 16'h0000, 1'b0, 16'h0000);
    repeat (3) @(posedge core_clk);
  endtask
  task wait_flag(input logic up);
    int i;
    for (i = 0; i < 3000 && (up ? node_up !== 1'b1 : survey_busy !== 1'b0); i++) @(posedge core_clk);
    #1;
    if (up) chk({15'h0000, node_up}, 16'h0001);
  endtask
  task join_try(input logic a);
    @(posedge core_clk);
    join_req <= 1'b1;
    @(posedge core_clk);
    join_req <= 1'b0;
    #1;
    chk({14'h0000, join_accept, join_refuse}, {14'h0000, a, !a});
  endtask
  task print_verdict;
    if (n_errors == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    {rst_n, cmd_valid, cmd_write, beacon_net, join_req, wake_pin, reject} = '0;
    {cmd_sel, cmd_wdata, n_errors, comparisons, cyc, polls, assocs} = '0;
    own_network_tag = 16'h1234;
    own_radio_lane = 5'h0D;
    peer_tag = 16'h1234;
    quiet_lane = 5'h0C;
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    cmd(1'b0, 3'h0, 16'h0000, 1'b0, 16'h0000);
    cmd(1'b0, 3'h2, 16'h0000, 1'b0, 16'h0004);
    cmd(1'b0, 3'h3, 16'h0000, 1'b0, 16'h0000);
    cmd(1'b0, 3'h4, 16'h0000, 1'b0, 16'h0000);
    cmd(1'b1, 3'h0, 16'h0002, 1'b1, 16'h0000);
    cmd(1'b1, 3'h2, 16'h0010, 1'b1, 16'h0000);
    cmd(1'b0, 3'h6, 16'h0000, 1'b1, 16'h0000);
    cmd(1'b0, 3'h7, 16'h0000, 1'b1, 16'h0000);
    cmd(1'b1, 3'h3, 16'hFFF0, 1'b0, 16'h0000);
    cmd(1'b0, 3'h3, 16'h0000, 1'b0, 16'h0000);
    cmd(1'b1, 3'h4, 16'hFFF8, 1'b0, 16'h0000);
    cmd(1'b0, 3'h4, 16'h0000, 1'b0, 16'h0000);
    // automatic joining is off, so the boot request leaves the end device idle
    cmd(1'b0, 3'h5, 16'h0000, 1'b0, 16'h0001);
    chk(16'(assocs), 16'h0000);
    cmd(1'b1, 3'h0, 16'h0001, 1'b0, 16'h0000);
    cmd(1'b1, 3'h4, 16'h0001, 1'b0, 16'h0000);
    restart;
    wait_flag(1'b1);
    chk(16'(lanes.size()), 16'h0010);
    chk(16'(at[1] - at[0]), 16'h0044);
    chk(op_network_tag, 16'h1235);
    cmd(1'b1, 3'h0, 16'h0000, 1'b0, 16'h0000);
    cmd(1'b1, 3'h1, 16'h0006, 1'b0, 16'h0000);
    cmd(1'b0, 3'h1, 16'h0000, 1'b0, 16'h0006);
    cmd(1'b1, 3'h2, 16'h0001, 1'b0, 16'h0000);
    cmd(1'b1, 3'h3, 16'h000C, 1'b0, 16'h0000);
    restart;
    wait_flag(1'b1);
    chk({lanes[0], lanes[1], 6'h00}, {5'h0C, 5'h0D, 6'h00});
    chk(16'(at[1] - at[0]), 16'h000C);
    chk({11'h000, assoc_lane}, 16'h000D);
    chk(assoc_tag, 16'h1234);
    cmd(1'b0, 3'h5, 16'h0000, 1'b0, 16'h0010);
    polls = 0;
    @(posedge core_clk);
    wake_pin <= 1'b1;
    repeat (6) @(posedge core_clk);
    wake_pin <= 1'b0;
    chk(16'(polls), 16'h0001);
    peer_tag = 16'h5555;
    beacon_net <= 1'b1;
    cmd(1'b1, 3'h3, 16'h0001, 1'b0, 16'h0000);
    restart;
    wait_flag(1'b1);
    chk(assoc_tag, 16'h5555);
    peer_tag = 16'h1234;
    beacon_net <= 1'b0;
    cmd(1'b1, 3'h0, 16'h0001, 1'b0, 16'h0000);
    cmd(1'b1, 3'h1, 16'h0003, 1'b0, 16'h0000);
    cmd(1'b1, 3'h4, 16'h0007, 1'b0, 16'h0000);
    restart;
    wait_flag(1'b1);
    chk(op_network_tag, 16'h1235);
    chk({11'h000, op_radio_lane}, 16'h000C);
    join_try(1'b1);
    cmd(1'b1, 3'h4, 16'h0000, 1'b0, 16'h0000);
    restart;
    wait_flag(1'b1);
    chk({op_network_tag[10:0], op_radio_lane}, {11'h234, 5'h0D});
    join_try(1'b0);
    print_verdict;
  end
endmodule
bind network_join_config network_join_config_checker i_network_join_config_checker (.*);
